// File: design/ifm_pkg.sv
// Constants, field layouts and types shared by the input function mapper
package ifm_pkg;
    localparam int IFM_NUM_INPUTS = 8;
    localparam int IFM_CODE_W = 8;
    localparam int IFM_NUM_FUNCS = 19;
    localparam int IFM_ADR_W = 8;
    localparam int IFM_RAMP_W = 16;

    // Function codes handled here
    localparam logic [7:0] IFM_CODE_FIRST = 8'h06;
    localparam logic [7:0] IFM_CODE_REVERSE = 8'h06;
    localparam logic [7:0] IFM_CODE_HALT = 8'h07;
    localparam logic [7:0] IFM_CODE_START = 8'h08;
    localparam logic [7:0] IFM_CODE_TRQ_LIM = 8'h09;
    localparam logic [7:0] IFM_CODE_VEL_LIM = 8'h10;
    localparam logic [7:0] IFM_CODE_IDX_B0 = 8'h11;
    localparam logic [7:0] IFM_CODE_IDX_B1 = 8'h12;
    localparam logic [7:0] IFM_CODE_IDX_B2 = 8'h13;
    localparam logic [7:0] IFM_CODE_VSEL_B0 = 8'h14;
    localparam logic [7:0] IFM_CODE_VSEL_B1 = 8'h15;
    localparam logic [7:0] IFM_CODE_TSEL_B0 = 8'h16;
    localparam logic [7:0] IFM_CODE_TSEL_B1 = 8'h17;
    localparam logic [7:0] IFM_CODE_VP_SWITCH = 8'h18;

    // Register byte offsets
    localparam logic [7:0] IFM_OFS_CODE_BASE = 8'h00;
    localparam logic [7:0] IFM_OFS_LIMIT_CFG = 8'h20;
    localparam logic [7:0] IFM_OFS_MODE_CFG = 8'h24;
    localparam logic [7:0] IFM_OFS_HALT_RAMP = 8'h28;
    localparam logic [7:0] IFM_OFS_STATUS = 8'h2C;
    localparam logic [7:0] IFM_OFS_FUNC_STATUS = 8'h30;

    // Field positions
    localparam int IFM_LIM_TRQ_BIT = 0;
    localparam int IFM_LIM_VEL_BIT = 1;
    localparam int IFM_MODE_BASE_LSB = 0;
    localparam int IFM_MODE_PS_SEL_BIT = 2;
    localparam int IFM_STAT_MODE_LSB = 8;
    localparam int IFM_STAT_HALT_BIT = 10;
    localparam int IFM_STAT_START_BIT = 11;

    // Reset values
    localparam logic [7:0] IFM_CODE_RST = 8'h00;
    localparam logic [1:0] IFM_LIMIT_RST = 2'h0;
    localparam logic [2:0] IFM_MODE_RST = 3'h0;
    localparam logic [15:0] IFM_HALT_RAMP_RST = 16'h0000;

    typedef enum logic [1:0] {
        IFM_MODE_VEL = 2'h0,
        IFM_MODE_TRQ = 2'h1,
        IFM_MODE_PT = 2'h2,
        IFM_MODE_PS = 2'h3
    } ifm_mode_e;

    typedef enum logic [1:0] {
        IFM_ST_RUN = 2'h1,
        IFM_ST_HALT = 2'h2
    } ifm_halt_e;
endpackage

// File: design/ifm_map_if.sv
// Carries function codes and decoded function levels between mapper modules
`timescale 1ns/1ps
interface ifm_map_if;
    logic [7:0] code [0:7];
    logic [7:0] level;
    logic [18:0] func;
    modport ctrl (output code, input level, input func);
    modport dec (input code, output level, output func);
endinterface

// File: design/ifm_decoder.sv
// Input synchroniser and function code decoder
`timescale 1ns/1ps
module ifm_decoder (
    input wire logic clock,
    input wire logic rst,
    input wire logic [ifm_pkg::IFM_NUM_INPUTS-1:0] din,
    ifm_map_if.dec map
);
    import ifm_pkg::*;

    logic [IFM_NUM_INPUTS-1:0] meta_reg;
    logic [IFM_NUM_INPUTS-1:0] sync_reg;
    logic [IFM_NUM_FUNCS-1:0] func_next;

    function automatic logic code_hit(input logic [7:0] code, input int idx);
        code_hit = (code == 8'(int'(IFM_CODE_FIRST) + idx));
    endfunction

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_reg <= 8'h00;
            sync_reg <= 8'h00;
        end else begin
            meta_reg <= din;
            sync_reg <= meta_reg;
        end
    end

    always_comb begin
        func_next = '0;
        for (int f = 0; f < IFM_NUM_FUNCS; f++) begin
            for (int i = 0; i < IFM_NUM_INPUTS; i++) begin
                if (code_hit(map.code[i], f) && sync_reg[i]) begin
                    func_next[f] = 1'b1;
                end
            end
        end
    end

    assign map.level = sync_reg;
    assign map.func = func_next;
endmodule

// File: design/ifm_input_function_mapper.sv
// Top of the input function mapper: registers, mode resolution, function outputs
// Summary of operation
// - Code 06h reverses motor rotation, effective only in velocity and torque modes.
// - Code 07h going active halts movement using the halt ramp setting.
// - Movement resumes as soon as the halt function returns inactive.
// - Code 08h starts the selected data set, only in position sequence mode.
// - Torque limits are enabled by code 09h OR the limit enable setting.
// - Velocity limits are enabled by code 10h OR the limit enable setting.
// - Codes 11h, 12h, 13h give bits 0, 1, 2 of the five-bit data set index.
// - Codes 14h, 15h give the two-bit velocity reference selector used in velocity mode.
// - Codes 16h, 17h give the two-bit torque reference selector used in torque mode.
// - Code 18h selects velocity mode when low, pulse train or position sequence when high.
// - Each of the eight inputs has its own function code setting.
`timescale 1ns/1ps
module ifm_input_function_mapper (
    input wire logic clock,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ifm_pkg::IFM_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [ifm_pkg::IFM_NUM_INPUTS-1:0] digital_input,
    output logic reverse_rotation,
    output logic halt_request,
    output logic resume_pulse,
    output logic [ifm_pkg::IFM_RAMP_W-1:0] halt_ramp,
    output logic dataset_start,
    output logic dataset_start_pulse,
    output logic torque_limit_enable,
    output logic velocity_limit_enable,
    output logic [4:0] dataset_index,
    output logic [1:0] velocity_ref_sel,
    output logic [1:0] torque_ref_sel,
    output logic [1:0] operating_mode
);
    import ifm_pkg::*;

    ifm_map_if map ();

    // Configuration registers
    logic [7:0] code_reg [0:7];
    logic [1:0] limit_cfg_reg;
    logic [2:0] mode_cfg_reg;
    logic [15:0] halt_ramp_reg;

    // Bus state
    logic ack_reg;
    logic [31:0] rdata_reg;

    // Function state
    ifm_halt_e halt_reg;
    ifm_halt_e halt_next;
    logic resume_reg;
    logic start_prev_reg;
    logic start_pulse_reg;
    logic reverse_reg;
    logic start_reg;
    logic trq_lim_reg;
    logic vel_lim_reg;
    logic [4:0] index_reg;
    logic [1:0] vsel_reg;
    logic [1:0] tsel_reg;
    logic [1:0] mode_reg;

    // Byte-lane merge for partial writes
    function automatic logic [31:0] lane_merge(input logic [31:0] old_val, input logic [31:0] new_val,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old_val;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = new_val[8*b +: 8];
            end
        end
        lane_merge = r;
    endfunction

    // Function level by code
    function automatic logic fn(input logic [18:0] v, input logic [7:0] code);
        fn = v[5'(code - IFM_CODE_FIRST)];
    endfunction

    // Any input carries the given code
    function automatic logic code_used(input logic [7:0] c0, input logic [7:0] c1, input logic [7:0] c2,
                                       input logic [7:0] c3, input logic [7:0] c4, input logic [7:0] c5,
                                       input logic [7:0] c6, input logic [7:0] c7, input logic [7:0] code);
        code_used = (c0 == code) || (c1 == code) || (c2 == code) || (c3 == code) ||
                    (c4 == code) || (c5 == code) || (c6 == code) || (c7 == code);
    endfunction

    // Bus decode
    wire bus_req = wb_cyc_i && wb_stb_i;
    wire bus_wr = bus_req && wb_we_i && ack_reg;
    wire [7:0] word_adr = {wb_adr_i[7:2], 2'b00};
    wire code_sel = (word_adr < IFM_OFS_LIMIT_CFG);
    wire [2:0] code_idx = wb_adr_i[4:2];
    wire limit_sel = (word_adr == IFM_OFS_LIMIT_CFG);
    wire mode_sel = (word_adr == IFM_OFS_MODE_CFG);
    wire ramp_sel = (word_adr == IFM_OFS_HALT_RAMP);
    wire status_sel = (word_adr == IFM_OFS_STATUS);
    wire fstat_sel = (word_adr == IFM_OFS_FUNC_STATUS);

    // Merged write values
    wire [31:0] code_wval = lane_merge({24'h000000, code_reg[code_idx]}, wb_dat_i, wb_sel_i);
    wire [31:0] limit_wval = lane_merge({30'h0, limit_cfg_reg}, wb_dat_i, wb_sel_i);
    wire [31:0] mode_wval = lane_merge({29'h0, mode_cfg_reg}, wb_dat_i, wb_sel_i);
    wire [31:0] ramp_wval = lane_merge({16'h0000, halt_ramp_reg}, wb_dat_i, wb_sel_i);

    // Decoded function levels
    wire [18:0] f = map.func;
    wire f_reverse = fn(f, IFM_CODE_REVERSE);
    wire f_halt = fn(f, IFM_CODE_HALT);
    wire f_start = fn(f, IFM_CODE_START);
    wire f_trq_lim = fn(f, IFM_CODE_TRQ_LIM);
    wire f_vel_lim = fn(f, IFM_CODE_VEL_LIM);
    wire f_switch = fn(f, IFM_CODE_VP_SWITCH);

    // switch only overrides the base mode once a code 18h input exists
    wire switch_assigned = code_used(code_reg[0], code_reg[1], code_reg[2], code_reg[3],
                                     code_reg[4], code_reg[5], code_reg[6], code_reg[7],
                                     IFM_CODE_VP_SWITCH);
    wire [1:0] position_mode = mode_cfg_reg[IFM_MODE_PS_SEL_BIT] ? IFM_MODE_PS : IFM_MODE_PT;
    wire [1:0] switched_mode = f_switch ? position_mode : IFM_MODE_VEL;
    wire [1:0] base_mode = mode_cfg_reg[IFM_MODE_BASE_LSB +: 2];
    wire [1:0] mode_next = switch_assigned ? switched_mode : base_mode;

    wire in_vel = (mode_next == IFM_MODE_VEL);
    wire in_trq = (mode_next == IFM_MODE_TRQ);
    wire in_ps = (mode_next == IFM_MODE_PS);

    // reversal only in velocity or torque mode
    wire reverse_next = f_reverse && (in_vel || in_trq);
    // start only in position sequence mode
    wire start_next = f_start && in_ps;
    // torque limit from input or setting
    wire trq_lim_next = f_trq_lim || limit_cfg_reg[IFM_LIM_TRQ_BIT];
    // velocity limit from input or setting
    wire vel_lim_next = f_vel_lim || limit_cfg_reg[IFM_LIM_VEL_BIT];
    // upper two index bits are tied to zero; codes 11h to 13h give the low three
    wire [4:0] index_next = {2'b00, fn(f, IFM_CODE_IDX_B2), fn(f, IFM_CODE_IDX_B1), fn(f, IFM_CODE_IDX_B0)};
    wire [1:0] vsel_next = {fn(f, IFM_CODE_VSEL_B1), fn(f, IFM_CODE_VSEL_B0)};
    wire [1:0] tsel_next = {fn(f, IFM_CODE_TSEL_B1), fn(f, IFM_CODE_TSEL_B0)};

    // Read data selection
    wire [31:0] status_word = {20'h00000, start_reg, (halt_reg == IFM_ST_HALT), mode_reg, map.level};
    wire [31:0] rdata_next = code_sel ? {24'h000000, code_reg[code_idx]} :
                             limit_sel ? {30'h0, limit_cfg_reg} :
                             mode_sel ? {29'h0, mode_cfg_reg} :
                             ramp_sel ? {16'h0000, halt_ramp_reg} :
                             status_sel ? status_word :
                             fstat_sel ? {13'h0, f} :
                             32'h00000000;

    ifm_decoder u_decoder (
        .clock(clock),
        .rst(rst),
        .din(digital_input),
        .map(map)
    );

    assign map.code = code_reg;

    // One wait state; a write lands on the acknowledging edge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
        end else begin
            ack_reg <= bus_req && !ack_reg;
            rdata_reg <= rdata_next;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < IFM_NUM_INPUTS; i++) begin
                code_reg[i] <= IFM_CODE_RST;
            end
        end else if (bus_wr && code_sel) begin
            code_reg[code_idx] <= code_wval[7:0];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            limit_cfg_reg <= IFM_LIMIT_RST;
        end else if (bus_wr && limit_sel) begin
            limit_cfg_reg <= limit_wval[1:0];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_cfg_reg <= IFM_MODE_RST;
        end else if (bus_wr && mode_sel) begin
            mode_cfg_reg <= mode_wval[2:0];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            halt_ramp_reg <= IFM_HALT_RAMP_RST;
        end else if (bus_wr && ramp_sel) begin
            halt_ramp_reg <= ramp_wval[15:0];
        end
    end

    // halt on active input; resume on release
    always_comb begin
        case (halt_reg)
            IFM_ST_RUN: begin
                halt_next = f_halt ? IFM_ST_HALT : IFM_ST_RUN;
            end
            IFM_ST_HALT: begin
                halt_next = f_halt ? IFM_ST_HALT : IFM_ST_RUN;
            end
            default: begin
                halt_next = IFM_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            halt_reg <= IFM_ST_RUN;
            resume_reg <= 1'b0;
        end else begin
            halt_reg <= halt_next;
            resume_reg <= (halt_reg == IFM_ST_HALT) && (halt_next == IFM_ST_RUN);
        end
    end

    // edge pulse so a held input starts one data set only
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            start_prev_reg <= 1'b0;
            start_pulse_reg <= 1'b0;
        end else begin
            start_prev_reg <= start_next;
            start_pulse_reg <= start_next && !start_prev_reg;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reverse_reg <= 1'b0;
        end else begin
            reverse_reg <= reverse_next;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            start_reg <= 1'b0;
        end else begin
            start_reg <= start_next;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            trq_lim_reg <= 1'b0;
        end else begin
            trq_lim_reg <= trq_lim_next;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            vel_lim_reg <= 1'b0;
        end else begin
            vel_lim_reg <= vel_lim_next;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            index_reg <= 5'h00;
        end else begin
            index_reg <= index_next;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            vsel_reg <= 2'h0;
        end else begin
            vsel_reg <= vsel_next;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tsel_reg <= 2'h0;
        end else begin
            tsel_reg <= tsel_next;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_reg <= IFM_MODE_VEL;
        end else begin
            mode_reg <= mode_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;
    assign reverse_rotation = reverse_reg;
    assign halt_request = (halt_reg == IFM_ST_HALT);
    assign halt_ramp = halt_ramp_reg;
    assign resume_pulse = resume_reg;
    assign dataset_start = start_reg;
    assign dataset_start_pulse = start_pulse_reg;
    assign torque_limit_enable = trq_lim_reg;
    assign velocity_limit_enable = vel_lim_reg;
    assign dataset_index = index_reg;
    assign velocity_ref_sel = vsel_reg;
    assign torque_ref_sel = tsel_reg;
    assign operating_mode = mode_reg;
endmodule

// File: tb/ifm_mapper_props.sv
// Checker of bus handshake and function output relations for the mapper
`timescale 1ns/1ps
module ifm_mapper_props (
    input wire logic clock,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic wb_ack_o,
    input wire logic reverse_rotation,
    input wire logic halt_request,
    input wire logic resume_pulse,
    input wire logic [ifm_pkg::IFM_RAMP_W-1:0] halt_ramp,
    input wire logic dataset_start,
    input wire logic dataset_start_pulse,
    input wire logic [4:0] dataset_index,
    input wire logic [1:0] operating_mode
);
    import ifm_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_ack_one_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not given one cycle after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_rev_mode_gate: assert property (reverse_rotation |-> operating_mode inside {IFM_MODE_VEL, IFM_MODE_TRQ})
        else $error("reverse active outside velocity or torque mode");
    a_start_ps_only: assert property (dataset_start |-> operating_mode == IFM_MODE_PS)
        else $error("data set start outside position sequence mode");
    a_index_upper_zero: assert property (dataset_index[4:3] == 2'h0)
        else $error("data set index upper bits driven");
    a_resume_after_halt: assert property ($fell(halt_request) |-> ##[0:1] resume_pulse)
        else $error("no resume after halt release");
    a_resume_single: assert property (resume_pulse |=> !resume_pulse && !halt_request)
        else $error("resume pulse too long or halt still set");
    a_start_pulse_edge: assert property ($rose(dataset_start) |-> ##[0:1] dataset_start_pulse)
        else $error("no start pulse on data set start");
    a_ramp_by_write: assert property ($changed(halt_ramp) |->
        ($past(wb_ack_o) && $past(wb_we_i)) || ($past(wb_ack_o, 2) && $past(wb_we_i, 2)))
        else $error("halt ramp changed without a write");
endmodule

// File: tb/ifm_switch_model.sv
// Behavioural switch bank that drives the mapper's digital inputs
`timescale 1ns/1ps
module ifm_switch_model (
    input wire logic clock,
    input wire logic [7:0] switch_level,
    output logic [7:0] digital_input
);
    // Contacts settle off the clock edge, so the mapper must synchronise them
    initial begin
        digital_input = 8'h00;
        forever begin
            @(posedge clock);
            digital_input <= #1 switch_level;
        end
    end
endmodule

// File: tb/tb_input_function_mapper.sv
// Self-checking bench for the input function mapper
`timescale 1ns/1ps
module tb_input_function_mapper;
    import ifm_pkg::*;
    logic clock;
    logic rst;
    logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [7:0] switch_level, digital_input;
    logic reverse_rotation, halt_request, resume_pulse, dataset_start, dataset_start_pulse;
    logic torque_limit_enable, velocity_limit_enable;
    logic [15:0] halt_ramp;
    logic [4:0] dataset_index;
    logic [1:0] velocity_ref_sel, torque_ref_sel, operating_mode;
    logic [15:0] fn_vec;
    logic [7:0] code_a [0:7] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h10, 8'h11, 8'h12, 8'h13};
    logic [7:0] code_b [0:7] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h0A, 8'h05, 8'h19};
    int num_errors = 0;
    int checks_done = 0;
    assign fn_vec = {reverse_rotation, halt_request, dataset_start, torque_limit_enable, velocity_limit_enable,
                     dataset_index, velocity_ref_sel, torque_ref_sel, operating_mode};

    ifm_input_function_mapper u_ifm_input_function_mapper (.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .digital_input(digital_input),
        .reverse_rotation(reverse_rotation), .halt_request(halt_request), .resume_pulse(resume_pulse),
        .halt_ramp(halt_ramp), .dataset_start(dataset_start), .dataset_start_pulse(dataset_start_pulse),
        .torque_limit_enable(torque_limit_enable), .velocity_limit_enable(velocity_limit_enable),
        .dataset_index(dataset_index), .velocity_ref_sel(velocity_ref_sel), .torque_ref_sel(torque_ref_sel),
        .operating_mode(operating_mode));
    ifm_switch_model u_ifm_switch_model (.clock(clock), .switch_level(switch_level),
        .digital_input(digital_input));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    function automatic logic [15:0] fv(logic rv, logic hl, logic st, logic tq, logic vl, logic [4:0] ix,
                                       logic [1:0] vs, logic [1:0] ts, logic [1:0] md);
        return {rv, hl, st, tq, vl, ix, vs, ts, md};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= 4'hF;
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        check({31'h0, wb_ack_o}, 32'h1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] unused;
        wb_cycle(1'b1, adr, dat, unused);
    endtask

    task automatic rd_check(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] got;
        wb_cycle(1'b0, adr, 32'h0, got);
        check(got, exp);
    endtask

    // Input path is model edge plus two sync edges plus output register
    task automatic apply(input logic [7:0] pat, input logic [15:0] exp);
        switch_level <= pat;
        repeat (8) @(posedge clock);
        check({16'h0, fn_vec}, {16'h0, exp});
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        complete_run;
    end

    initial begin
        rst = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        switch_level = 8'h00;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        check({16'h0, fn_vec}, 32'h0);
        rd_check(IFM_OFS_CODE_BASE, 32'h0);
        rd_check(IFM_OFS_LIMIT_CFG, 32'h0);
        rd_check(IFM_OFS_MODE_CFG, 32'h0);
        rd_check(IFM_OFS_HALT_RAMP, 32'h0);
        wr(8'h3C, 32'hFFFF_FFFF);
        rd_check(8'h3C, 32'h0);
        // each code on one input only
        for (int i = 0; i < 8; i++) wr(IFM_OFS_CODE_BASE + 8'(4 * i), {24'h0, code_a[i]});
        rd_check(IFM_OFS_CODE_BASE + 8'h1C, 32'h13);
        wr(IFM_OFS_HALT_RAMP, 32'h0000_1234);
        rd_check(IFM_OFS_HALT_RAMP, 32'h1234);
        check({16'h0, halt_ramp}, 32'h1234);
        wr(IFM_OFS_MODE_CFG, 32'h1);
        apply(8'hFF, fv(1, 1, 0, 1, 1, 5'h07, 2'h0, 2'h0, 2'h1));
        wr(IFM_OFS_MODE_CFG, 32'h3);
        apply(8'hFF, fv(0, 1, 1, 1, 1, 5'h07, 2'h0, 2'h0, 2'h3));
        apply(8'h50, fv(0, 0, 0, 0, 1, 5'h02, 2'h0, 2'h0, 2'h3));
        wr(IFM_OFS_LIMIT_CFG, 32'h1);
        apply(8'h00, fv(0, 0, 0, 1, 0, 5'h00, 2'h0, 2'h0, 2'h3));
        wr(IFM_OFS_LIMIT_CFG, 32'h2);
        wr(IFM_OFS_MODE_CFG, 32'h0);
        apply(8'h01, fv(1, 0, 0, 0, 1, 5'h00, 2'h0, 2'h0, 2'h0));
        apply(8'h80, fv(0, 0, 0, 0, 1, 5'h04, 2'h0, 2'h0, 2'h0));
        wr(IFM_OFS_LIMIT_CFG, 32'h0);
        // second map, also with unused and out-of-range codes
        for (int i = 0; i < 8; i++) wr(IFM_OFS_CODE_BASE + 8'(4 * i), {24'h0, code_b[i]});
        wr(IFM_OFS_MODE_CFG, 32'h4);
        apply(8'hFF, fv(0, 0, 0, 0, 0, 5'h00, 2'h3, 2'h3, 2'h3));
        apply(8'h15, fv(0, 0, 0, 0, 0, 5'h00, 2'h1, 2'h1, 2'h3));
        wr(IFM_OFS_MODE_CFG, 32'h0);
        apply(8'h0A, fv(0, 0, 0, 0, 0, 5'h00, 2'h2, 2'h2, 2'h0));
        apply(8'h1A, fv(0, 0, 0, 0, 0, 5'h00, 2'h2, 2'h2, 2'h2));
        rd_check(IFM_OFS_STATUS, 32'h0000_021A);
        rd_check(IFM_OFS_FUNC_STATUS, 32'h0006_8000);
        complete_run;
    end
endmodule

bind ifm_input_function_mapper ifm_mapper_props u_ifm_mapper_props (.clock(clock), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
    .reverse_rotation(reverse_rotation), .halt_request(halt_request), .resume_pulse(resume_pulse),
    .halt_ramp(halt_ramp), .dataset_start(dataset_start), .dataset_start_pulse(dataset_start_pulse),
    .dataset_index(dataset_index), .operating_mode(operating_mode));
